// [core/mode_reg_pkg.sv]
/*
 * constants for the mode register bank (addresses 02h..08h): addresses,
 * field positions, reset values and code encodings.
 * assumes the user compiles it before the bank files.
 */
`default_nettype none

package mode_reg_pkg;
    // mode register addresses
    localparam logic [7:0] ADDR_LATENCY = 8'h02;
    localparam logic [7:0] ADDR_IO_DRIVE = 8'h03;
    localparam logic [7:0] ADDR_TEMP = 8'h04;
    localparam logic [7:0] ADDR_MAKER = 8'h05;
    localparam logic [7:0] ADDR_DIE_REV = 8'h06;
    localparam logic [7:0] ADDR_SEC_REV = 8'h07;
    localparam logic [7:0] ADDR_GEOMETRY = 8'h08;

    // field positions
    localparam int CODE_LSB = 0;
    localparam int CODE_MSB = 3;
    localparam int RATE_MSB = 2;
    localparam int FLAG_POS = 7;
    localparam int HOT_POS = 2;

    // reset values of the write-only codes, the rate status and the latency pair
    localparam logic [3:0] LATENCY_RESET = 4'h1;
    localparam logic [3:0] DRIVE_RESET = 4'h2;
    localparam logic [2:0] RATE_RESET = 3'h3;
    localparam logic [3:0] READ_LAT_RESET = 4'h3;
    localparam logic [2:0] WRITE_LAT_RESET = 3'h1;

    // latency codes and their read/write latencies
    localparam logic [3:0] LAT_3_1 = 4'h1;
    localparam logic [3:0] LAT_4_2 = 4'h2;
    localparam logic [3:0] LAT_5_2 = 4'h3;
    localparam logic [3:0] LAT_6_3 = 4'h4;
    localparam logic [3:0] LAT_7_4 = 4'h5;
    localparam logic [3:0] LAT_8_4 = 4'h6;

    // drive strength codes
    localparam logic [3:0] DRV_34R3 = 4'h1;
    localparam logic [3:0] DRV_40R = 4'h2;
    localparam logic [3:0] DRV_48R = 4'h3;
    localparam logic [3:0] DRV_60R = 4'h4;
    localparam logic [3:0] DRV_80R = 4'h6;
    localparam logic [3:0] DRV_120R = 4'h7;

    // refresh-rate status codes
    localparam logic [2:0] RATE_TOO_COLD = 3'h0;
    localparam logic [2:0] RATE_X4 = 3'h1;
    localparam logic [2:0] RATE_X2 = 3'h2;
    localparam logic [2:0] RATE_X1 = 3'h3;
    localparam logic [2:0] RATE_RSVD = 3'h4;
    localparam logic [2:0] RATE_QTR = 3'h5;
    localparam logic [2:0] RATE_QTR_DERATE = 3'h6;
    localparam logic [2:0] RATE_TOO_HOT = 3'h7;

    // device type field values
    localparam logic [1:0] TYPE_PREFETCH4 = 2'h0;
    localparam logic [1:0] TYPE_PREFETCH2 = 2'h1;

    // synchroniser depth for sensor inputs
    localparam int SYNC_STAGES = 3;
endpackage

`default_nettype wire

// [core/level_sync.sv]
/*
 * three-flop synchroniser for a bus of sensor levels; a new value is
 * passed on only once the second and third stages agree.
 * assumes inputs come from outside the clk_i domain.
 */
`default_nettype none

module level_sync #(
    parameter int WIDTH = 3
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // levels
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] stage1_r;
    logic [WIDTH-1:0] stage2_r;
    logic [WIDTH-1:0] stage3_r;

    // first stage feeds only the second
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            stage1_r <= '0;
            stage2_r <= '0;
            stage3_r <= '0;
        end else begin
            stage1_r <= async_i;
            stage2_r <= stage1_r;
            stage3_r <= stage2_r;
        end
    end

    // accept per bit only when stages two and three agree
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_bit
            always_ff @(posedge clk_i or posedge sys_rst_i) begin
                if (sys_rst_i) begin
                    sync_o[g] <= 1'b0;
                end else if (stage2_r[g] == stage3_r[g]) begin
                    sync_o[g] <= stage3_r[g];
                end
            end
        end
    endgenerate
endmodule // level_sync

`default_nettype wire

// [core/mode_reg_bank.sv]
/*
 * mode register bank for addresses 02h..08h of a low-power sdram:
 * latency and drive strength (write-only), temperature/refresh status
 * with its update flag (read-only, cleared by read), and identification.
 * assumes decoded mode register write/read strobes on clk_i from the
 * command decoder, and a refresh-rate code from the on-die sensor.
 */
// Contract
// - latency register at address 02h, low nibble
// - latency code selects read/write latency pair
// - drive register at address 03h, low nibble
// - drive code selects output impedance
// - temperature register 04h: rate low, flag top
// - 000b too cold, 111b too hot
// - rate codes give refresh multipliers and derating
// - reading temperature register clears the flag
// - flag is zero at power-up
// - rate bit 2 set above 85 C
// - fixed maker code at address 05h
// - die revision code at address 06h
// - secondary revision code at address 07h
// - geometry register 08h: width, density, type
`default_nettype none

module mode_reg_bank #(
    parameter logic [7:0] MAKER_ID = 8'h5a, // arbitrary value
    parameter logic [7:0] DIE_REV = 8'ha7, // arbitrary value
    parameter logic [7:0] SEC_REV = 8'h96, // arbitrary value
    parameter logic [1:0] IO_WIDTH = 2'h1,
    parameter logic [3:0] DENSITY = 4'h5,
    parameter logic [1:0] DEV_TYPE = mode_reg_pkg::TYPE_PREFETCH4
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // mode register access from the command decoder
    input wire logic mrw_i,
    input wire logic mrr_i,
    input wire logic [7:0] mode_reg_address_i,
    input wire logic [7:0] opcode_bits_i,
    // read answer
    output logic [7:0] read_data_o,
    output logic read_valid_o,
    // on-die sensor
    input wire logic [2:0] sensor_rate_i,
    // settings to the rest of the device
    output logic [3:0] read_latency_cycles_o,
    output logic [2:0] write_latency_cycles_o,
    output logic [3:0] output_drive_strength_o,
    output logic refresh_x4_o,
    output logic refresh_x2_o,
    output logic refresh_qtr_o,
    output logic derate_timing_o,
    output logic temp_out_of_range_o
);
    logic [3:0] latency_r;
    logic [3:0] drive_r;
    logic [2:0] rate_r;
    logic update_flag_r;
    logic [2:0] rate_sync;
    logic [3:0] read_lat_nxt;
    logic [2:0] write_lat_nxt;
    logic [7:0] rd_nxt;
    logic temp_read;
    logic rate_change;
    logic [2:0] settle_r;
    logic settled;
    logic primed_r;

    // sensor comes from an analogue domain, so it is synchronised
    level_sync #(
        .WIDTH(3)
    ) u_rate_sync (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .async_i(sensor_rate_i),
        .sync_o(rate_sync)
    );

    // latency register; a reserved code is ignored so the
    // device never runs on an undefined latency pair
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            latency_r <= mode_reg_pkg::LATENCY_RESET;
        end else if (mrw_i && mode_reg_address_i == mode_reg_pkg::ADDR_LATENCY
                     && opcode_bits_i[3:0] >= mode_reg_pkg::LAT_3_1
                     && opcode_bits_i[3:0] <= mode_reg_pkg::LAT_8_4) begin
            latency_r <= opcode_bits_i[3:0];
        end
    end

    // drive register; reserved codes also ignored
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            drive_r <= mode_reg_pkg::DRIVE_RESET;
        end else if (mrw_i
            && mode_reg_address_i == mode_reg_pkg::ADDR_IO_DRIVE) begin
            case (opcode_bits_i[3:0])
                mode_reg_pkg::DRV_34R3, mode_reg_pkg::DRV_40R,
                mode_reg_pkg::DRV_48R, mode_reg_pkg::DRV_60R,
                mode_reg_pkg::DRV_80R, mode_reg_pkg::DRV_120R: begin
                    drive_r <= opcode_bits_i[3:0];
                end
                default: begin
                    drive_r <= drive_r;
                end
            endcase
        end
    end

    // latency pair decode; the register never holds a reserved code,
    // so the default branch doubles as the reset pair
    always_comb begin
        case (latency_r)
            mode_reg_pkg::LAT_4_2: begin
                read_lat_nxt = 4'h4;
                write_lat_nxt = 3'h2;
            end
            mode_reg_pkg::LAT_5_2: begin
                read_lat_nxt = 4'h5;
                write_lat_nxt = 3'h2;
            end
            mode_reg_pkg::LAT_6_3: begin
                read_lat_nxt = 4'h6;
                write_lat_nxt = 3'h3;
            end
            mode_reg_pkg::LAT_7_4: begin
                read_lat_nxt = 4'h7;
                write_lat_nxt = 3'h4;
            end
            mode_reg_pkg::LAT_8_4: begin
                read_lat_nxt = 4'h8;
                write_lat_nxt = 3'h4;
            end
            default: begin
                read_lat_nxt = 4'h3;
                write_lat_nxt = 3'h1;
            end
        endcase
    end

    // read latency to the data path, one edge behind the register
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            read_latency_cycles_o <= mode_reg_pkg::READ_LAT_RESET;
        end else begin
            read_latency_cycles_o <= read_lat_nxt;
        end
    end

    // write latency to the data path, in step with the read latency
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            write_latency_cycles_o <= mode_reg_pkg::WRITE_LAT_RESET;
        end else begin
            write_latency_cycles_o <= write_lat_nxt;
        end
    end

    // drive code to the output stage
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            output_drive_strength_o <= mode_reg_pkg::DRIVE_RESET;
        end else begin
            output_drive_strength_o <= drive_r;
        end
    end

    // the synchroniser output means nothing until it has filled; count
    // those edges so no false too-cold status shows after reset
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            settle_r <= 3'h0;
        end else if (!settled) begin
            settle_r <= settle_r + 3'h1;
        end
    end

    assign settled = settle_r == 3'(mode_reg_pkg::SYNC_STAGES + 1);

    // status snapshot follows the synchronised sensor once it is valid
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rate_r <= mode_reg_pkg::RATE_RESET;
        end else if (settled) begin
            rate_r <= rate_sync;
        end
    end

    // the first load after reset is the power-up reading, not a change
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            primed_r <= 1'b0;
        end else begin
            primed_r <= settled;
        end
    end

    assign temp_read = mrr_i && mode_reg_address_i == mode_reg_pkg::ADDR_TEMP;
    assign rate_change = primed_r && rate_sync != rate_r;

    // update flag: a change in the read cycle wins over the clear,
    // so no change is ever lost to a racing read
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            update_flag_r <= 1'b0;
        end else if (rate_change) begin
            update_flag_r <= 1'b1;
        end else if (temp_read) begin
            update_flag_r <= 1'b0;
        end
    end

    // read multiplexer; write-only and unknown addresses read zero
    always_comb begin
        rd_nxt = 8'h00;
        case (mode_reg_address_i)
            mode_reg_pkg::ADDR_TEMP: begin
                rd_nxt[mode_reg_pkg::RATE_MSB:0] = rate_r;
                rd_nxt[mode_reg_pkg::FLAG_POS] = update_flag_r;
            end
            mode_reg_pkg::ADDR_MAKER: begin
                rd_nxt = MAKER_ID;
            end
            mode_reg_pkg::ADDR_DIE_REV: begin
                rd_nxt = DIE_REV;
            end
            mode_reg_pkg::ADDR_SEC_REV: begin
                rd_nxt = SEC_REV;
            end
            mode_reg_pkg::ADDR_GEOMETRY: begin
                rd_nxt = {IO_WIDTH, DENSITY, DEV_TYPE};
            end
            default: begin
                rd_nxt = 8'h00;
            end
        endcase
    end

    // registered read answer, one cycle after the strobe
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            read_data_o <= 8'h00;
            read_valid_o <= 1'b0;
        end else begin
            read_valid_o <= mrr_i;
            if (mrr_i) begin
                read_data_o <= rd_nxt;
            end
        end
    end

    // four-times refresh hint, decoded from the status
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            refresh_x4_o <= 1'b0;
        end else begin
            refresh_x4_o <= rate_r == mode_reg_pkg::RATE_X4;
        end
    end

    // twice refresh hint
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            refresh_x2_o <= 1'b0;
        end else begin
            refresh_x2_o <= rate_r == mode_reg_pkg::RATE_X2;
        end
    end

    // quarter refresh hint, with or without derating
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            refresh_qtr_o <= 1'b0;
        end else begin
            refresh_qtr_o <= rate_r == mode_reg_pkg::RATE_QTR
                || rate_r == mode_reg_pkg::RATE_QTR_DERATE;
        end
    end

    // derating is the controller's duty; the device only flags it
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            derate_timing_o <= 1'b0;
        end else begin
            derate_timing_o <=
                rate_r == mode_reg_pkg::RATE_QTR_DERATE;
        end
    end

    // operation not assured at either temperature limit
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            temp_out_of_range_o <= 1'b0;
        end else begin
            temp_out_of_range_o <= rate_r == mode_reg_pkg::RATE_TOO_COLD
                || rate_r == mode_reg_pkg::RATE_TOO_HOT;
        end
    end
endmodule // mode_reg_bank

`default_nettype wire

// [sim/mode_reg_bank_monitor.sv]
/* port checker for mode_reg_bank.
   assumes a bind that hands on the id parameters. */
`default_nettype none
module mode_reg_bank_monitor #(
    parameter logic [7:0] MAKER_ID = 8'h5a, // arbitrary value
    parameter logic [1:0] IO_WIDTH = 2'h0,
    parameter logic [3:0] DENSITY = 4'h0,
    parameter logic [1:0] DEV_TYPE = 2'h0
) (
    // clock, reset and access
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic mrw_i,
    input wire logic mrr_i,
    input wire logic [7:0] mode_reg_address_i,
    input wire logic [7:0] opcode_bits_i,
    input wire logic [7:0] read_data_o,
    input wire logic read_valid_o,
    // sensor and settings
    input wire logic [2:0] sensor_rate_i,
    input wire logic [3:0] read_latency_cycles_o,
    input wire logic [2:0] write_latency_cycles_o,
    input wire logic [3:0] output_drive_strength_o,
    input wire logic refresh_x4_o,
    input wire logic refresh_x2_o,
    input wire logic refresh_qtr_o,
    input wire logic derate_timing_o,
    input wire logic temp_out_of_range_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    // hints lag status by one edge, as does read data, so they agree here
    sequence s_temp;
        read_valid_o && $past(mode_reg_address_i) == mode_reg_pkg::ADDR_TEMP;
    endsequence
    property p_temp_rd;
        mrr_i && mode_reg_address_i == mode_reg_pkg::ADDR_TEMP
            |=> read_valid_o && read_data_o[6:3] == 4'h0;
    endproperty
    a_temp_rd: assert property (p_temp_rd)
        else $error("temperature answer malformed");
    property p_range;
        s_temp |-> temp_out_of_range_o ==
            (read_data_o[2:0] inside {3'h0, 3'h7});
    endproperty
    a_range: assert property (p_range)
        else $error("out of range hint wrong");
    property p_derate;
        s_temp |-> derate_timing_o == (read_data_o[2:0] == 3'h6) &&
            refresh_qtr_o == (read_data_o[2:0] inside {3'h5, 3'h6});
    endproperty
    a_derate: assert property (p_derate)
        else $error("quarter or derate hint wrong");
    property p_maker;
        mrr_i && mode_reg_address_i == mode_reg_pkg::ADDR_MAKER
            |=> read_data_o == MAKER_ID;
    endproperty
    a_maker: assert property (p_maker)
        else $error("maker code wrong");
    property p_geom;
        mrr_i && mode_reg_address_i == mode_reg_pkg::ADDR_GEOMETRY
            |=> read_data_o == {IO_WIDTH, DENSITY, DEV_TYPE};
    endproperty
    a_geom: assert property (p_geom)
        else $error("geometry answer wrong");
    property p_lat;
        mrw_i && mode_reg_address_i == mode_reg_pkg::ADDR_LATENCY &&
            opcode_bits_i[3:0] inside {[4'h1:4'h6]} |=> ##1
            read_latency_cycles_o == $past(opcode_bits_i[3:0], 2) + 4'h2;
    endproperty
    a_lat: assert property (p_lat)
        else $error("read latency not applied");
    property p_lat_rsvd;
        mrw_i && mode_reg_address_i == mode_reg_pkg::ADDR_LATENCY &&
            !(opcode_bits_i[3:0] inside {[4'h1:4'h6]}) |=> ##1
            $stable(read_latency_cycles_o) && $stable(write_latency_cycles_o);
    endproperty
    a_lat_rsvd: assert property (p_lat_rsvd)
        else $error("reserved latency code taken");
    property p_drv;
        mrw_i && mode_reg_address_i == mode_reg_pkg::ADDR_IO_DRIVE &&
            opcode_bits_i[3:0] inside {[4'h1:4'h4], 4'h6, 4'h7} |=> ##1
            output_drive_strength_o == $past(opcode_bits_i[3:0], 2);
    endproperty
    a_drv: assert property (p_drv)
        else $error("drive code not applied");
    c_hot: cover property (read_valid_o && read_data_o == 8'h87);
    c_flag: cover property (read_valid_o && read_data_o[7]);
    c_lat: cover property (mrw_i && opcode_bits_i == 8'h06);
endmodule // mode_reg_bank_monitor
`default_nettype wire

// [sim/mr_controller_model.sv]
/* memory controller model issuing mode register writes and reads.
   assumes the answer comes one cycle after the read strobe. */
`default_nettype none
module mr_controller_model (
    // clock and answer
    input wire logic clk_i,
    input wire logic [7:0] read_data_i,
    input wire logic read_valid_i,
    // requests
    output logic mrw_o,
    output logic mrr_o,
    output logic [7:0] addr_o,
    output logic [7:0] opcode_bits_o
);
    timeunit 1ns;
    timeprecision 1ns;
    real extra_ns = 0.0;
    bit unsafe = 1'b0;
    // released lines show the inverse so stale values never match
    task automatic wr(input logic [7:0] a, input logic [3:0] code);
        @(negedge clk_i);
        mrw_o = 1'b1;
        addr_o = a;
        opcode_bits_o = {4'h0, code};
        @(negedge clk_i);
        mrw_o = 1'b0;
        addr_o = ~a;
        opcode_bits_o = ~opcode_bits_o;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d,
        output bit ok);
        @(negedge clk_i);
        mrr_o = 1'b1;
        addr_o = a;
        @(negedge clk_i);
        mrr_o = 1'b0;
        addr_o = ~a;
        ok = read_valid_i;
        d = read_data_i;
        unsafe = d[2:0] inside {3'h0, 3'h7};
        extra_ns = (d[2:0] == 3'h6) ? 1.875 : 0.0;
    endtask
    initial begin
        mrw_o = 1'b0;
        mrr_o = 1'b0;
        addr_o = 8'h00;
        opcode_bits_o = 8'h00;
    end
endmodule // mr_controller_model
`default_nettype wire

// [sim/sdram_mode_register_bank_mr2_mr8_test.sv]
/* self-checking bench for the mode register bank.
   assumes the controller model and the port checker beside it. */
`default_nettype none
bind mode_reg_bank mode_reg_bank_monitor #(.MAKER_ID(MAKER_ID),
    .IO_WIDTH(IO_WIDTH), .DENSITY(DENSITY), .DEV_TYPE(DEV_TYPE)) mon (.*);
module sdram_mode_register_bank_mr2_mr8_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [2:0] sensor_rate_i = 3'h3;
    logic mrw_i, mrr_i, read_valid_o, refresh_x4_o, refresh_x2_o;
    logic refresh_qtr_o, derate_timing_o, temp_out_of_range_o;
    logic [7:0] mode_reg_address_i, opcode_bits_i, read_data_o, d;
    logic [3:0] read_latency_cycles_o, output_drive_strength_o;
    logic [3:0] exp_rd_lat, exp_wr_lat, exp_drive;
    logic [2:0] write_latency_cycles_o;
    logic [7:0] lat_pair, hints, exp_hints;
    // packed views of the latency pair and hint outputs, one byte each
    assign lat_pair = {read_latency_cycles_o, 1'b0, write_latency_cycles_o};
    assign hints = {3'h0, temp_out_of_range_o, derate_timing_o,
        refresh_qtr_o, refresh_x2_o, refresh_x4_o};
    int n_errors = 0;
    int num_checks = 0;
    bit ok;
    always #5 clk_i = ~clk_i;
    // id values are arbitrary
    // density keeps its default of 4'h5
    mode_reg_bank #(.MAKER_ID(8'h3c), .DIE_REV(8'h11), .SEC_REV(8'h4b),
        .IO_WIDTH(2'h1), .DEV_TYPE(2'h1)) dut (.*);
    mr_controller_model ctl (.clk_i(clk_i), .read_data_i(read_data_o),
        .read_valid_i(read_valid_o), .mrw_o(mrw_i), .mrr_o(mrr_i),
        .addr_o(mode_reg_address_i), .opcode_bits_o(opcode_bits_i));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic test_done;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // a missing answer ends the run at once
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        ctl.rd(a, d, ok);
        if (!ok) begin
            n_errors++;
            test_done();
        end else
            chk(d, exp);
    endtask
    initial begin
        repeat (12) @(posedge clk_i);
        @(negedge clk_i);
        sys_rst_i = 1'b0;
        chk(lat_pair, 8'h31);
        chk({4'h0, output_drive_strength_o}, 8'h02);
        repeat (8) @(negedge clk_i);
        // the power-up reading must leave the flag clear
        rd_chk(mode_reg_pkg::ADDR_TEMP, 8'h03);
        rd_chk(mode_reg_pkg::ADDR_TEMP, 8'h03);
        // every status code, each one a change from the last
        for (int r = 0; r < 8; r++) begin
            sensor_rate_i = r[2:0];
            repeat (8) @(negedge clk_i);
            rd_chk(mode_reg_pkg::ADDR_TEMP, 8'h80 | 8'(r));
            exp_hints = {3'h0, r == 0 || r == 7, r == 6, r == 5 || r == 6,
                r == 2, r == 1};
            chk(hints, exp_hints);
            rd_chk(mode_reg_pkg::ADDR_TEMP, 8'(r));
        end
        exp_rd_lat = 4'h3;
        exp_wr_lat = 4'h1;
        for (int c = 0; c < 16; c++) begin
            ctl.wr(mode_reg_pkg::ADDR_LATENCY, c[3:0]);
            if (c >= 1 && c <= 6) begin
                exp_rd_lat = c[3:0] + 4'h2;
                exp_wr_lat = 4'(32'h0443_2210 >> (4 * c));
            end
            repeat (2) @(negedge clk_i);
            chk(lat_pair, {exp_rd_lat, exp_wr_lat});
        end
        exp_drive = 4'h2;
        for (int c = 15; c >= 0; c--) begin
            ctl.wr(mode_reg_pkg::ADDR_IO_DRIVE, c[3:0]);
            if (((16'h00de >> c) & 16'h1) != 16'h0)
                exp_drive = c[3:0];
            repeat (2) @(negedge clk_i);
            chk(8'(output_drive_strength_o), 8'(exp_drive));
        end
        ctl.wr(mode_reg_pkg::ADDR_MAKER, 4'h0);
        rd_chk(mode_reg_pkg::ADDR_LATENCY, 8'h00);
        rd_chk(mode_reg_pkg::ADDR_IO_DRIVE, 8'h00);
        rd_chk(mode_reg_pkg::ADDR_MAKER, 8'h3c);
        rd_chk(mode_reg_pkg::ADDR_DIE_REV, 8'h11);
        rd_chk(mode_reg_pkg::ADDR_SEC_REV, 8'h4b);
        rd_chk(mode_reg_pkg::ADDR_GEOMETRY, 8'h55);
        rd_chk(8'h09, 8'h00);
        test_done();
    end
endmodule // sdram_mode_register_bank_mr2_mr8_test
`default_nettype wire
